// *** inc/ras_consts.svh ***
/*
 Constants for the return-address stack: widths, depth and field positions.
 Assumes it is included by bare name from design files.
*/
`ifndef RAS_CONSTS_SVH
`define RAS_CONSTS_SVH
`define RAS_ADDR_W 12
`define RAS_DEPTH 30
`define RAS_PTR_W 5
`define RAS_HI_NIB_MSB 3
`define RAS_HI_NIB_LSB 0
`define RAS_REG_W 8
`define RAS_PC_RESET 12'h000
`define RAS_PTR_RESET 5'h00
`define RAS_PC_STEP 12'h001
`endif

// *** inc/ras_pkg.sv ***
/*
 Types for the return-address stack.
 Assumes the constants header is compiled alongside.
*/
`include "ras_consts.svh"
package ras_pkg;
    typedef logic [`RAS_ADDR_W-1:0] ras_addr_t;
    typedef enum logic [2:0] {
        RAS_OP_NONE = 3'h0,
        RAS_OP_STEP = 3'h1,
        RAS_OP_JUMP = 3'h2,
        RAS_OP_CALL = 3'h3,
        RAS_OP_CALL_IND = 3'h4,
        RAS_OP_RET = 3'h5,
        RAS_OP_RETI = 3'h6,
        RAS_OP_IRQ = 3'h7
    } ras_op_t;
endpackage : ras_pkg

// *** rtl/ras_store.sv ***
/*
 Return-address storage array, flip-flops addressed by an index.
 Assumes the controller never writes and reads the same slot with conflicting intent.
*/
`timescale 1ns/1ps
`include "ras_consts.svh"
module ras_store #(
    parameter int DEPTH = `RAS_DEPTH,
    parameter int PTR_W = `RAS_PTR_W
) (
    // Clock.
    input wire logic clk_sys,
    // Write port.
    input wire logic wr_en,
    input wire logic [PTR_W-1:0] wr_idx,
    input wire ras_pkg::ras_addr_t wr_data,
    // Read port.
    input wire logic [PTR_W-1:0] rd_idx,
    output ras_pkg::ras_addr_t rd_data
);
    ras_pkg::ras_addr_t mem_reg [DEPTH];
    ras_pkg::ras_addr_t mem_next [DEPTH];

    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en && (int'(wr_idx) < DEPTH))
        begin
            mem_next[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem_reg[i] <= mem_next[i];
        end
    end

    // Out-of-range reads return zero rather than an undefined slot.
    assign rd_data = (int'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : '0;
endmodule : ras_store

// *** rtl/ras_core.sv ***
/*
 Program-counter sequencer with return-address stack for a small 8-bit core.
 Assumes a decoder presents one operation per cycle on op with its operands.
*/
`timescale 1ns/1ps
`include "ras_consts.svh"
module ras_core #(
    parameter int DEPTH = `RAS_DEPTH,
    parameter int PTR_W = `RAS_PTR_W
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Operation from decoder.
    input wire ras_pkg::ras_op_t op,
    input wire ras_pkg::ras_addr_t target_addr,
    input wire logic [`RAS_REG_W-1:0] target_high_register,
    input wire logic [`RAS_REG_W-1:0] target_low_register,
    // Sequencer state.
    output ras_pkg::ras_addr_t pc,
    output logic [PTR_W-1:0] depth,
    output logic fault_reset
);
    ras_pkg::ras_addr_t pc_reg, pc_next;
    logic [PTR_W-1:0] ptr_reg, ptr_next;
    logic fault_reg, fault_next;
    logic wr_en;
    logic [PTR_W-1:0] rd_idx;
    ras_pkg::ras_addr_t top_addr;
    logic [`RAS_HI_NIB_MSB:`RAS_HI_NIB_LSB] ind_hi_nib;

    function automatic ras_pkg::ras_addr_t ind_target(input logic [`RAS_REG_W-1:0] hi,
                                                       input logic [`RAS_REG_W-1:0] lo);
        ind_target = {hi[`RAS_HI_NIB_MSB:`RAS_HI_NIB_LSB], lo};
    endfunction : ind_target

    function automatic logic is_push(input ras_pkg::ras_op_t o);
        is_push = (o == ras_pkg::RAS_OP_CALL) || (o == ras_pkg::RAS_OP_CALL_IND) || (o == ras_pkg::RAS_OP_IRQ);
    endfunction : is_push

    function automatic logic is_pop(input ras_pkg::ras_op_t o);
        is_pop = (o == ras_pkg::RAS_OP_RET) || (o == ras_pkg::RAS_OP_RETI);
    endfunction : is_pop

    // The stack has no software port: only this sequencer reaches it.
    ras_store #(.DEPTH(DEPTH), .PTR_W(PTR_W)) u_store (
        .clk_sys(clk_sys),
        .wr_en(wr_en),
        .wr_idx(ptr_reg),
        .wr_data(pc_reg),
        .rd_idx(rd_idx),
        .rd_data(top_addr)
    );

    assign rd_idx = ptr_reg - PTR_W'(1);
    assign ind_hi_nib = target_high_register[`RAS_HI_NIB_MSB:`RAS_HI_NIB_LSB];

    always_comb
    begin
        pc_next = pc_reg + `RAS_PC_STEP;
        ptr_next = ptr_reg;
        fault_next = 1'b0;
        wr_en = 1'b0;
        case (op)
            ras_pkg::RAS_OP_NONE:
            begin
                pc_next = pc_reg;
            end
            ras_pkg::RAS_OP_STEP:
            begin
                pc_next = pc_reg + `RAS_PC_STEP;
            end
            ras_pkg::RAS_OP_JUMP:
            begin
                pc_next = target_addr;
            end
            ras_pkg::RAS_OP_CALL, ras_pkg::RAS_OP_CALL_IND, ras_pkg::RAS_OP_IRQ:
            begin
                // Overflow resets rather than silently corrupting return flow.
                if (int'(ptr_reg) >= DEPTH)
                begin
                    fault_next = 1'b1;
                end
                else
                begin
                    wr_en = 1'b1;
                    ptr_next = ptr_reg + PTR_W'(1);
                    if (op == ras_pkg::RAS_OP_CALL_IND)
                    begin
                        pc_next = ind_target(target_high_register, target_low_register);
                    end
                    else
                    begin
                        pc_next = target_addr;
                    end
                end
            end
            ras_pkg::RAS_OP_RET, ras_pkg::RAS_OP_RETI:
            begin
                if (ptr_reg == `RAS_PTR_RESET)
                begin
                    fault_next = 1'b1;
                end
                else
                begin
                    ptr_next = ptr_reg - PTR_W'(1);
                    pc_next = top_addr + `RAS_PC_STEP;
                end
            end
            default:
            begin
                pc_next = pc_reg;
            end
        endcase
        if (fault_next)
        begin
            pc_next = `RAS_PC_RESET;
            ptr_next = `RAS_PTR_RESET;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pc_reg <= `RAS_PC_RESET;
            ptr_reg <= `RAS_PTR_RESET;
            fault_reg <= 1'b0;
        end
        else
        begin
            pc_reg <= pc_next;
            ptr_reg <= ptr_next;
            fault_reg <= fault_next;
        end
    end

    assign pc = pc_reg;
    assign depth = ptr_reg;
    assign fault_reset = fault_reg;

    ret_pop_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_RET && ptr_reg != `RAS_PTR_RESET) |=> (pc_reg == $past(top_addr) + `RAS_PC_STEP))
        else $error("Return did not load saved address plus one.");

    under_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
        (is_pop(op) && ptr_reg == `RAS_PTR_RESET)
        |=> (fault_reg && pc_reg == `RAS_PC_RESET && ptr_reg == `RAS_PTR_RESET))
        else $error("Underflow did not force reset.");

    irq_push_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_IRQ && int'(ptr_reg) < DEPTH) |=> (ptr_reg == $past(ptr_reg) + 1'b1))
        else $error("Interrupt entry did not take a level.");

    reti_pop_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_RETI && ptr_reg != `RAS_PTR_RESET)
        |=> (pc_reg == $past(top_addr) + `RAS_PC_STEP && ptr_reg == $past(ptr_reg) - 1'b1))
        else $error("Interrupt return did not free its level.");

    irq_save_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_IRQ && int'(ptr_reg) < DEPTH)
        |=> (u_store.mem_reg[$past(ptr_reg)] == $past(pc_reg) && pc_reg == $past(target_addr)))
        else $error("Interrupt entry did not save its address.");

    depth_max_a: assert property (@(posedge clk_sys) disable iff (srst)
        int'(ptr_reg) <= DEPTH)
        else $error("Stack depth exceeded capacity.");

    push_depth_a: assert property (@(posedge clk_sys) disable iff (srst)
        (is_push(op) && int'(ptr_reg) < DEPTH) |=> (ptr_reg == $past(ptr_reg) + 1'b1))
        else $error("Push did not deepen the stack by one.");

    pop_depth_a: assert property (@(posedge clk_sys) disable iff (srst)
        (is_pop(op) && ptr_reg != `RAS_PTR_RESET) |=> (ptr_reg == $past(ptr_reg) - 1'b1))
        else $error("Pop did not shrink the stack by one.");

    stack_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        (!is_push(op) && !is_pop(op)) |=> $stable(ptr_reg))
        else $error("Stack depth moved without a stack operation.");

    store_wr_a: assert property (@(posedge clk_sys) disable iff (srst)
        wr_en |-> (is_push(op) && int'(ptr_reg) < DEPTH))
        else $error("Stack written outside a legal push.");

    ind_call_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_CALL_IND && int'(ptr_reg) < DEPTH)
        |=> (pc_reg == {$past(ind_hi_nib), $past(target_low_register)}))
        else $error("Indirect call target wrong.");

    push_save_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_CALL_IND && int'(ptr_reg) < DEPTH)
        |=> (u_store.mem_reg[$past(ptr_reg)] == $past(pc_reg)))
        else $error("Indirect call did not save its own address.");

    call_save_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_CALL && int'(ptr_reg) < DEPTH)
        |=> (u_store.mem_reg[$past(ptr_reg)] == $past(pc_reg)))
        else $error("Call did not save its own address.");

    call_tgt_a: assert property (@(posedge clk_sys) disable iff (srst)
        (op == ras_pkg::RAS_OP_CALL && int'(ptr_reg) < DEPTH) |=> (pc_reg == $past(target_addr)))
        else $error("Call did not load its target.");

    over_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
        (is_push(op) && int'(ptr_reg) >= DEPTH) |=> (fault_reg && ptr_reg == `RAS_PTR_RESET))
        else $error("Overflow did not force reset.");

    fault_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
        fault_reg |-> (ptr_reg == `RAS_PTR_RESET && pc_reg == `RAS_PC_RESET))
        else $error("Fault left pointer or counter set.");

    no_fault_a: assert property (@(posedge clk_sys) disable iff (srst)
        (!(is_push(op) && int'(ptr_reg) >= DEPTH) && !(is_pop(op) && ptr_reg == `RAS_PTR_RESET))
        |=> !fault_reg)
        else $error("Fault raised without overflow or underflow.");
endmodule : ras_core

// *** test/tb_top.sv ***
/*
 Self-checking bench for the return-address stack: a queue model checks pc, depth and fault every cycle.
 Assumes ras_core with its default depth and the shared constants header.
*/
`timescale 1ns/1ps
`include "ras_consts.svh"
module tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    ras_pkg::ras_op_t op = ras_pkg::RAS_OP_NONE;
    ras_pkg::ras_addr_t target_addr = 12'h000;
    logic [7:0] target_high_register = 8'h00;
    logic [7:0] target_low_register = 8'h00;
    ras_pkg::ras_addr_t pc;
    logic [4:0] depth;
    logic fault_reset;
    int failures = 0;
    int compares = 0;
    bit chk_on = 1'b0;
    logic [11:0] m_pc = 12'h000;
    logic [11:0] m_stk[$];
    logic m_flt = 1'b0;
    ras_pkg::ras_op_t calls[3] = '{ras_pkg::RAS_OP_CALL, ras_pkg::RAS_OP_CALL_IND, ras_pkg::RAS_OP_IRQ};

    always #2.5 clk_sys = ~clk_sys;

    ras_core u_ras_core (.clk_sys(clk_sys), .srst(srst), .op(op), .target_addr(target_addr),
        .target_high_register(target_high_register), .target_low_register(target_low_register),
        .pc(pc), .depth(depth), .fault_reset(fault_reset));

    task chk_pc(input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED pc expected %h seen %h", exp, got);
        end
    endtask : chk_pc

    task chk_depth(input logic [4:0] exp, input logic [4:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED depth expected %0d seen %0d", exp, got);
        end
    endtask : chk_depth

    task chk_fault(input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED fault expected %b seen %b", exp, got);
        end
    endtask : chk_fault

    // Outputs are compared at the falling edge, after the rising edge's updates have landed.
    always @(negedge clk_sys)
    begin
        if (chk_on)
        begin
            chk_pc(m_pc, pc);
            chk_depth(5'(m_stk.size()), depth);
            chk_fault(m_flt, fault_reset);
        end
    end

    // Entered on a rising edge; the model follows the edge at which the design takes the op.
    task step(input ras_pkg::ras_op_t o, input logic [11:0] t, input logic [7:0] h, input logic [7:0] l);
        logic bad;
        op <= o;
        target_addr <= t;
        target_high_register <= h;
        target_low_register <= l;
        @(posedge clk_sys);
        bad = 1'b0;
        case (o)
            ras_pkg::RAS_OP_STEP: m_pc = m_pc + 12'h001;
            ras_pkg::RAS_OP_JUMP: m_pc = t;
            ras_pkg::RAS_OP_CALL, ras_pkg::RAS_OP_CALL_IND, ras_pkg::RAS_OP_IRQ:
            begin
                bad = (m_stk.size() == `RAS_DEPTH);
                m_stk.push_back(m_pc);
                m_pc = (o == ras_pkg::RAS_OP_CALL_IND) ? {h[3:0], l} : t;
            end
            ras_pkg::RAS_OP_RET, ras_pkg::RAS_OP_RETI:
            begin
                bad = (m_stk.size() == 0);
                if (!bad)
                    m_pc = m_stk.pop_back() + 12'h001;
            end
            default: ;
        endcase
        if (bad)
        begin
            m_pc = 12'h000;
            m_stk.delete();
        end
        m_flt = bad;
    endtask : step

    task rnd_call;
        step(calls[$urandom_range(2, 0)], 12'($urandom), 8'($urandom), 8'($urandom));
    endtask : rnd_call

    task wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        void'($urandom(32'hff1b));
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        chk_on = 1'b1;
        step(ras_pkg::RAS_OP_STEP, 12'h000, 8'h00, 8'h00);
        step(ras_pkg::RAS_OP_CALL, 12'h5a4, 8'h00, 8'h00);
        step(ras_pkg::RAS_OP_CALL_IND, 12'h000, 8'hfa, 8'h49);
        step(ras_pkg::RAS_OP_RET, 12'h000, 8'h00, 8'h00);
        step(ras_pkg::RAS_OP_RETI, 12'h000, 8'h00, 8'h00);
        $display("test call_return done");
        for (int i = 0; i < 31; i++)
            rnd_call();
        step(ras_pkg::RAS_OP_RET, 12'h000, 8'h00, 8'h00);
        $display("test overflow_underflow done");
        for (int i = 0; i < 30; i++)
            rnd_call();
        for (int i = 0; i < 31; i++)
            step(i[0] ? ras_pkg::RAS_OP_RET : ras_pkg::RAS_OP_RETI, 12'h000, 8'h00, 8'h00);
        $display("test nest_unwind done");
        for (int i = 0; i < 400; i++)
            step(ras_pkg::ras_op_t'($urandom_range(7, 0)), 12'($urandom), 8'($urandom), 8'($urandom));
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        m_pc = 12'h000;
        m_stk.delete();
        m_flt = 1'b0;
        step(ras_pkg::RAS_OP_RET, 12'h000, 8'h00, 8'h00);
        step(ras_pkg::RAS_OP_NONE, 12'h000, 8'h00, 8'h00);
        $display("test random_reset done");
        wrap_up();
    end
endmodule : tb_top
